// ===== src/bmd_pkg.sv
// Contract
// - i/o space holds 2048 16-bit locations; only low eleven address lines are driven; the code drives the upper three low.
// - i/o waits come from four 3-bit region fields plus mode bit, by address quarter.
// - composite select asserts, same timing, with any individually enabled memory select.
// - composite enables reset to one, except the byte-space enable which resets to zero.
// - composite select follows bus grant handling like other selects, released while granted.
// - byte select enabled at reset for booting; software may disable it later.
// - byte space is 256 pages of 16k bytes, read and write.
// - byte on data 15:8; page on data 23:16 and address 13:0 form 22 bits.
// - every byte access waits per 4-bit byte wait field with mode bit, up to 15.
// - engine runs beside the core, stealing one cycle per internal word.
// - type 00 pm 24-bit, 01 dm 16-bit, 10 dm upper byte, 11 dm lower byte.
// - in 8-bit data formats unused word bits are written as zeros.
// - setup takes internal start address, 14-bit in-page address and 8-bit page.
// - direction bit selects load from byte space or store to byte space.
// - writing nonzero 14-bit word count starts accesses until count reaches zero.
// - count decrements per word, is readable, and at zero engine stops and interrupts.
// - sequential external addressing carries across page boundaries.
// - each word moves to or from on-chip memory in one cycle, never external.
// - a core external access request is served before a pending byte access.
// - context reset bit 0 keeps core running; 1 halts it, restarts at zero.
// - boot strap resets setup to zero, type pm, count 32 and context reset one.
package bmd_pkg;
	localparam int unsigned EA_W   = 14;
	localparam int unsigned PAGE_W = 8;
	localparam int unsigned CNT_W  = 14;
	localparam int unsigned WORD_W = 24;
	localparam int unsigned IOA_W  = 11;
	localparam int unsigned NREGS  = 9;

	localparam logic [5:0] OFF_CTRL  = 6'h00;
	localparam logic [5:0] OFF_IADDR = 6'h04;
	localparam logic [5:0] OFF_EADDR = 6'h08;
	localparam logic [5:0] OFF_PAGE  = 6'h0c;
	localparam logic [5:0] OFF_COUNT = 6'h10;
	localparam logic [5:0] OFF_WAIT  = 6'h14;
	localparam logic [5:0] OFF_CSEL  = 6'h18;
	localparam logic [5:0] OFF_SYS   = 6'h1c;
	localparam logic [5:0] OFF_STAT  = 6'h20;

	localparam int unsigned CTRL_DIR_BIT  = 2;
	localparam int unsigned CTRL_CTX_BIT  = 3;
	localparam int unsigned CTRL_OVL_LSB  = 4;
	localparam int unsigned WAIT_MODE_BIT = 15;
	localparam int unsigned SYS_BDIS_BIT  = 4;
	localparam int unsigned STAT_DONE_BIT = 1;
	localparam int unsigned CS_PM         = 0;
	localparam int unsigned CS_DM         = 1;
	localparam int unsigned CS_BYTE       = 2;
	localparam int unsigned CS_IO         = 3;

	localparam logic [3:0]       CSEL_RST   = 4'hb;
	localparam logic [3:0]       BWAIT_RST  = 4'hf;
	localparam logic [11:0]      IOWAIT_RST = 12'h000;
	localparam logic [CNT_W-1:0] BOOT_COUNT = 14'h0020;

	localparam logic [1:0] TYPE_PM24 = 2'h0;
	localparam logic [1:0] TYPE_DM16 = 2'h1;
	localparam logic [1:0] TYPE_DMHI = 2'h2;
	localparam logic [1:0] SPACE_PM  = 2'h0;
	localparam logic [1:0] SPACE_DM  = 2'h1;
	localparam logic [1:0] SPACE_IO  = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {ST_IDLE, ST_EXT, ST_FETCH, ST_CAPT, ST_WORD} bmd_state_t;
endpackage

// ===== src/bmd_wait_timer.sv
`timescale 1ns/1ps
`default_nettype none
module bmd_wait_timer (
	input  wire logic       sys_clk_i,
	input  wire logic       reset_n_i,
	input  wire logic       ce_i,
	input  wire logic       start_i,
	input  wire logic [3:0] waits_i,
	output logic            active_o,
	output logic            done_o
);
	logic       act_r;
	logic [3:0] cnt_r;

	// an access lasts waits plus one cycles; done marks its last cycle
	assign active_o = act_r;
	assign done_o   = act_r & (cnt_r == 4'h0);

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			act_r <= 1'b0;
			cnt_r <= 4'h0;
		end else if (ce_i) begin
			if (start_i) begin
				act_r <= 1'b1;
				cnt_r <= waits_i;
			end else if (done_o) begin
				act_r <= 1'b0;
			end else if (act_r) begin
				cnt_r <= cnt_r - 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== src/bmd_top.sv
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module bmd_top (
	input  wire logic        sys_clk_i,
	input  wire logic        reset_n_i,
	input  wire logic        ce_i,
	input  wire logic [5:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [5:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	input  wire logic        boot_dma_i,
	input  wire logic        bus_request_n_i,
	output logic             bus_grant_n_o,
	input  wire logic        core_ext_req_i,
	input  wire logic        core_ext_write_i,
	input  wire logic [1:0]  core_ext_space_i,
	input  wire logic [13:0] core_ext_addr_i,
	input  wire logic [23:0] core_ext_wdata_i,
	output logic             core_ext_ack_o,
	output logic [23:0]      core_ext_rdata_o,
	output logic             imem_req_o,
	output logic             imem_write_o,
	output logic             imem_prog_o,
	output logic [13:0]      imem_addr_o,
	output logic [23:0]      imem_wdata_o,
	input  wire logic [23:0] imem_rdata_i,
	output logic             core_steal_o,
	output logic             core_hold_o,
	output logic             core_restart_o,
	output logic             dma_done_o,
	output logic [13:0]      ext_addr_o,
	output logic [23:0]      ext_data_o,
	output logic [1:0]       ext_data_oe_o,
	input  wire logic [23:0] ext_data_i,
	output logic             ext_rd_n_o,
	output logic             ext_wr_n_o,
	output logic             ext_bus_oe_o,
	output logic             program_space_select_n_o,
	output logic             data_space_select_n_o,
	output logic             byte_space_select_n_o,
	output logic             io_space_select_n_o,
	output logic             composite_select_n_o
);
	function automatic logic [3:0] eff_wait(input logic [3:0] f, input logic m);
		eff_wait = m ? ((f > 4'h7) ? 4'hf : {f[2:0], 1'b1}) : f;
	endfunction

	function automatic logic [1:0] need_bytes(input logic [1:0] t);
		need_bytes = (t == bmd_pkg::TYPE_PM24) ? 2'd3 : ((t == bmd_pkg::TYPE_DM16) ? 2'd2 : 2'd1);
	endfunction

	// registers
	logic [1:0]  type_r;
	logic        dir_r, ctx_r, done_r, bsel_dis_r, wmode_r, fetched_r, bg_r, done_pulse_r;
	logic [3:0]  ovl_r, csel_r, bwait_r;
	logic [13:0] iaddr_r, eaddr_r, count_r;
	logic [7:0]  page_r;
	logic [11:0] iowait_r;
	logic [23:0] word_r;
	logic [1:0]  bidx_r;
	bmd_pkg::bmd_state_t state_r, state_nxt;
	// pin-side flops
	logic [13:0] addr_r;
	logic [23:0] dout_r, din_s1, din_s2;
	logic [1:0]  doe_r;
	logic        rd_r, wr_r, pms_r, dms_r, bms_r, io_space_select_n_r, acc_core_r;
	logic        breq_s1, breq_s2, boot_s1, boot_s2, strap_taken_r;
	logic [1:0]  strap_cnt_r;
	// bus slave
	logic        aw_full_r, w_full_r, bvalid_r, rvalid_r;
	logic [5:0]  awaddr_r;
	logic [31:0] wdata_r, rdata_r;
	logic [3:0]  wstrb_r;
	logic [1:0]  bresp_r, rresp_r;

	wire        busy_w   = (count_r != 14'h0000);

	// register views, addressed by word index
	logic [15:0] view [bmd_pkg::NREGS];
	assign view[0] = {8'h00, ovl_r, ctx_r, dir_r, type_r};
	assign view[1] = {2'b00, iaddr_r};
	assign view[2] = {2'b00, eaddr_r};
	assign view[3] = {8'h00, page_r};
	assign view[4] = {2'b00, count_r};
	assign view[5] = {wmode_r, 3'b000, iowait_r};
	assign view[6] = {12'h000, csel_r};
	assign view[7] = {11'h000, bsel_dis_r, bwait_r};
	assign view[8] = {14'h0000, done_r, busy_w};

	wire [3:0]  aw_idx   = awaddr_r[5:2];
	wire [3:0]  ar_idx   = s_axi_araddr_i[5:2];
	wire        aw_ok    = (awaddr_r[1:0] == 2'b00) && (aw_idx < 4'd9);
	wire        ar_ok    = (s_axi_araddr_i[1:0] == 2'b00) && (ar_idx < 4'd9);
	wire        wr_fire  = aw_full_r & w_full_r & ~bvalid_r;
	wire        ar_fire  = s_axi_arvalid_i & ~rvalid_r;
	wire [15:0] cur_w    = aw_ok ? view[aw_idx] : 16'h0000;
	wire [15:0] wv       = {wstrb_r[1] ? wdata_r[15:8] : cur_w[15:8],
		wstrb_r[0] ? wdata_r[7:0] : cur_w[7:0]};
	wire [8:0]  we       = (wr_fire & aw_ok) ? (9'h001 << aw_idx) : 9'h000;

	assign s_axi_awready_o = ~aw_full_r;
	assign s_axi_wready_o  = ~w_full_r;
	assign s_axi_arready_o = ~rvalid_r;
	assign s_axi_bvalid_o  = bvalid_r;
	assign s_axi_bresp_o   = bresp_r;
	assign s_axi_rvalid_o  = rvalid_r;
	assign s_axi_rdata_o   = rdata_r;
	assign s_axi_rresp_o   = rresp_r;

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			aw_full_r <= 1'b0;
			w_full_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			rvalid_r  <= 1'b0;
			awaddr_r  <= 6'h00;
			wdata_r   <= 32'h0000_0000;
			wstrb_r   <= 4'h0;
			bresp_r   <= bmd_pkg::RESP_OKAY;
			rdata_r   <= 32'h0000_0000;
			rresp_r   <= bmd_pkg::RESP_OKAY;
		end else if (ce_i) begin
			if (s_axi_awvalid_i & ~aw_full_r) begin
				aw_full_r <= 1'b1;
				awaddr_r  <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i & ~w_full_r) begin
				w_full_r <= 1'b1;
				wdata_r  <= s_axi_wdata_i;
				wstrb_r  <= s_axi_wstrb_i;
			end
			if (wr_fire) begin
				aw_full_r <= 1'b0;
				w_full_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= aw_ok ? bmd_pkg::RESP_OKAY : bmd_pkg::RESP_SLVERR;
			end else if (s_axi_bready_i) begin
				bvalid_r <= 1'b0;
			end
			if (ar_fire) begin
				rvalid_r <= 1'b1;
				rdata_r  <= {16'h0000, ar_ok ? view[ar_idx] : 16'h0000};
				rresp_r  <= ar_ok ? bmd_pkg::RESP_OKAY : bmd_pkg::RESP_SLVERR;
			end else if (s_axi_rready_i) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	// access scheduling
	logic       tmr_active, tmr_done;
	wire        can_start = (state_r == bmd_pkg::ST_IDLE) & ~bg_r & breq_s2 & ~tmr_active;
	wire        core_go   = can_start & core_ext_req_i;
	wire        dma_go    = can_start & ~core_ext_req_i & busy_w;
	wire        fetch_go  = dma_go & dir_r & ~fetched_r;
	wire        byte_go   = dma_go & ~(dir_r & ~fetched_r);
	wire        acc_done  = (state_r == bmd_pkg::ST_EXT) & tmr_done;
	wire        byte_done = acc_done & ~acc_core_r;
	wire        last_byte = byte_done & ((bidx_r + 2'd1) == need_bytes(type_r));
	wire        word_end  = (last_byte & dir_r) | (state_r == bmd_pkg::ST_WORD);
	wire        core_io   = (core_ext_space_i == bmd_pkg::SPACE_IO);
	wire [1:0]  io_reg    = core_ext_addr_i[10:9];
	wire [3:0]  io_field  = {1'b0, iowait_r[3*io_reg +: 3]};
	wire [3:0]  core_wait = core_io ? eff_wait(io_field, wmode_r) : 4'h0;
	wire [3:0]  byte_wait = eff_wait(bwait_r, wmode_r);
	wire [3:0]  tmr_waits = core_go ? core_wait : byte_wait;
	wire [7:0]  byte_in   = din_s2[15:8];
	wire [23:0] asm_w     = {word_r[15:0], byte_in};
	wire        sw_count  = we[4];
	wire        boot_load = (strap_cnt_r == 2'd2) & ~strap_taken_r & boot_s2;

	bmd_wait_timer u_timer (
		.sys_clk_i (sys_clk_i),
		.reset_n_i (reset_n_i),
		.ce_i      (ce_i),
		.start_i   (core_go | byte_go),
		.waits_i   (tmr_waits),
		.active_o  (tmr_active),
		.done_o    (tmr_done)
	);

	// cycles since a core access was taken; only the i/o wait check reads it
	logic [3:0] io_len_r;
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			io_len_r <= 4'h0;
		else if (ce_i)
			io_len_r <= core_go ? 4'h0 : io_len_r + 4'h1;
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			bmd_pkg::ST_IDLE: begin
				if (core_go | byte_go)
					state_nxt = bmd_pkg::ST_EXT;
				else if (fetch_go)
					state_nxt = bmd_pkg::ST_FETCH;
			end
			bmd_pkg::ST_EXT: begin
				if (last_byte & ~dir_r)
					state_nxt = bmd_pkg::ST_WORD;
				else if (acc_done)
					state_nxt = bmd_pkg::ST_IDLE;
			end
			bmd_pkg::ST_FETCH: state_nxt = bmd_pkg::ST_CAPT;
			default: state_nxt = bmd_pkg::ST_IDLE;
		endcase
	end

	// one-cycle internal memory slot per word; the core loses only that cycle
	assign imem_req_o   = (state_r == bmd_pkg::ST_WORD) | (state_r == bmd_pkg::ST_FETCH);
	assign core_steal_o = imem_req_o;
	assign imem_write_o = (state_r == bmd_pkg::ST_WORD);
	assign imem_prog_o  = (type_r == bmd_pkg::TYPE_PM24);
	assign imem_addr_o  = iaddr_r;
	assign imem_wdata_o = word_r;
	assign core_hold_o  = busy_w & ctx_r;
	assign core_restart_o = done_pulse_r & ctx_r;
	assign dma_done_o   = done_pulse_r;
	assign core_ext_ack_o = acc_done & acc_core_r;
	assign core_ext_rdata_o = din_s2;

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_r <= bmd_pkg::ST_IDLE;
			bidx_r  <= 2'd0;
			word_r  <= 24'h000000;
			fetched_r <= 1'b0;
		end else if (ce_i) begin
			state_r <= state_nxt;
			if (state_r == bmd_pkg::ST_CAPT) begin
				fetched_r <= 1'b1;
				case (type_r)
					2'h0: word_r <= imem_rdata_i;
					2'h1: word_r <= {imem_rdata_i[15:0], 8'h00};
					2'h2: word_r <= {imem_rdata_i[15:8], 16'h0000};
					default: word_r <= {imem_rdata_i[7:0], 16'h0000};
				endcase
			end
			if (byte_done) begin
				bidx_r <= last_byte ? 2'd0 : bidx_r + 2'd1;
				if (dir_r) begin
					word_r <= {word_r[15:0], 8'h00};
					if (last_byte)
						fetched_r <= 1'b0;
				end else if (last_byte) begin
					case (type_r)
						2'h0: word_r <= asm_w;
						2'h1: word_r <= {8'h00, asm_w[15:0]};
						2'h2: word_r <= {8'h00, asm_w[7:0], 8'h00};
						default: word_r <= {16'h0000, asm_w[7:0]};
					endcase
				end else begin
					word_r <= asm_w;
				end
			end
		end
	end

	// setup and count; software writes win over engine updates
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			type_r  <= bmd_pkg::TYPE_PM24;
			dir_r   <= 1'b0;
			ctx_r   <= 1'b0;
			ovl_r   <= 4'h0;
			iaddr_r <= 14'h0000;
			eaddr_r <= 14'h0000;
			page_r  <= 8'h00;
			count_r <= 14'h0000;
		end else if (ce_i) begin
			if (we[0]) begin
				type_r <= wv[1:0];
				dir_r  <= wv[bmd_pkg::CTRL_DIR_BIT];
				ctx_r  <= wv[bmd_pkg::CTRL_CTX_BIT];
				ovl_r  <= wv[bmd_pkg::CTRL_OVL_LSB +: 4];
			end else if (boot_load) begin
				ctx_r <= 1'b1;
			end
			if (we[1])
				iaddr_r <= wv[13:0];
			else if (word_end)
				iaddr_r <= iaddr_r + 14'h0001;
			if (we[2] | we[3] | byte_done) begin
				eaddr_r <= we[2] ? wv[13:0] : (byte_done ? eaddr_r + 14'h0001 : eaddr_r);
				// carry out of the in-page address walks into the next page
				page_r <= we[3] ? wv[7:0]
					: ((byte_done & (eaddr_r == 14'h3fff)) ? page_r + 8'h01 : page_r);
			end
			if (sw_count)
				count_r <= wv[13:0];
			else if (boot_load)
				count_r <= bmd_pkg::BOOT_COUNT;
			else if (word_end & busy_w)
				count_r <= count_r - 14'h0001;
		end
	end

	// config, status, strap and bus grant
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wmode_r    <= 1'b0;
			iowait_r   <= bmd_pkg::IOWAIT_RST;
			csel_r     <= bmd_pkg::CSEL_RST;
			bwait_r    <= bmd_pkg::BWAIT_RST;
			bsel_dis_r <= 1'b0;
			done_r     <= 1'b0;
			done_pulse_r <= 1'b0;
			boot_s1 <= 1'b0;
			boot_s2 <= 1'b0;
			breq_s1 <= 1'b1;
			breq_s2 <= 1'b1;
			strap_cnt_r   <= 2'd0;
			strap_taken_r <= 1'b0;
			bg_r <= 1'b0;
		end else if (ce_i) begin
			if (we[5]) begin
				wmode_r  <= wv[bmd_pkg::WAIT_MODE_BIT];
				iowait_r <= wv[11:0];
			end
			if (we[6])
				csel_r <= wv[3:0];
			if (we[7]) begin
				bwait_r    <= wv[3:0];
				bsel_dis_r <= wv[bmd_pkg::SYS_BDIS_BIT];
			end
			done_pulse_r <= word_end & (count_r == 14'h0001) & ~sw_count;
			// a completion in the clearing cycle is kept
			if (done_pulse_r)
				done_r <= 1'b1;
			else if (we[8] & wv[bmd_pkg::STAT_DONE_BIT])
				done_r <= 1'b0;
			boot_s1 <= boot_dma_i;
			boot_s2 <= boot_s1;
			breq_s1 <= bus_request_n_i;
			breq_s2 <= breq_s1;
			// strap is caught once, after the synchroniser has filled
			if (strap_cnt_r != 2'd2)
				strap_cnt_r <= strap_cnt_r + 2'd1;
			else
				strap_taken_r <= 1'b1;
			if (breq_s2)
				bg_r <= 1'b0;
			else if ((state_r == bmd_pkg::ST_IDLE) & ~tmr_active)
				bg_r <= 1'b1;
		end
	end

	// external pins
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			addr_r <= 14'h0000;
			dout_r <= 24'h000000;
			doe_r  <= 2'b00;
			din_s1 <= 24'h000000;
			din_s2 <= 24'h000000;
			{rd_r, wr_r, pms_r, dms_r, bms_r, io_space_select_n_r, acc_core_r} <= 7'h00;
		end else if (ce_i) begin
			din_s1 <= ext_data_i;
			din_s2 <= din_s1;
			if (core_go) begin
				acc_core_r <= 1'b1;
				// upper i/o address lines are driven low rather than left floating
				addr_r <= core_io ? {3'b000, core_ext_addr_i[bmd_pkg::IOA_W-1:0]}
					: core_ext_addr_i;
				dout_r <= core_ext_wdata_i;
				doe_r  <= {2{core_ext_write_i}};
				rd_r   <= ~core_ext_write_i;
				wr_r   <= core_ext_write_i;
				pms_r  <= (core_ext_space_i == bmd_pkg::SPACE_PM);
				dms_r  <= (core_ext_space_i == bmd_pkg::SPACE_DM);
				io_space_select_n_r <= core_io;
			end else if (byte_go) begin
				acc_core_r <= 1'b0;
				addr_r <= eaddr_r;
				dout_r <= {page_r, word_r[23:16], 8'h00};
				doe_r  <= {1'b1, dir_r};
				rd_r   <= ~dir_r;
				wr_r   <= dir_r;
				bms_r  <= 1'b1;
			end else if (acc_done) begin
				{rd_r, wr_r, pms_r, dms_r, bms_r, io_space_select_n_r} <= 6'h00;
				doe_r <= 2'b00;
			end
		end
	end

	wire [3:0] sel_vec = {io_space_select_n_r, bms_r, dms_r, pms_r};
	assign ext_bus_oe_o  = ~bg_r;
	assign bus_grant_n_o = ~bg_r;
	assign ext_addr_o    = addr_r;
	assign ext_data_o    = dout_r;
	assign ext_data_oe_o = doe_r & {2{~bg_r}};
	assign ext_rd_n_o    = ~rd_r;
	assign ext_wr_n_o    = ~wr_r;
	assign program_space_select_n_o = ~pms_r;
	assign data_space_select_n_o    = ~dms_r;
	assign io_space_select_n_o      = ~io_space_select_n_r;
	assign byte_space_select_n_o    = ~(bms_r & ~bsel_dis_r);
	assign composite_select_n_o     = ~|(sel_vec & csel_r);

	default clocking dc @(posedge sys_clk_i iff ce_i); endclocking
	default disable iff (!reset_n_i);

	sequence page_wrap_s;
		byte_done && !we[2] && !we[3] && (eaddr_r == 14'h3fff);
	endsequence
	sequence word_done_s;
		word_end && busy_w && !sw_count && !boot_load;
	endsequence

	io_addr_high_a: assert property (io_space_select_n_r |-> ext_addr_o[13:11] == 3'b000)
		else $error("i/o access drives upper address lines");
	io_wait_sel_a: assert property (core_ext_ack_o && io_space_select_n_r && !wmode_r
		|-> io_len_r == {1'b0, iowait_r[3*addr_r[10:9] +: 3]})
		else $error("i/o wait count does not match region field");
	comp_follow_a: assert property ((bms_r && csel_r[bmd_pkg::CS_BYTE]) || (pms_r && csel_r[0])
		|-> !composite_select_n_o)
		else $error("composite select missed an enabled select");
	byte_dis_a: assert property (bsel_dis_r |-> byte_space_select_n_o)
		else $error("byte select asserted while disabled");
	grant_float_a: assert property (bg_r |-> !ext_bus_oe_o && ext_data_oe_o == 2'b00)
		else $error("outputs driven while bus granted");
	steal_one_a: assert property (core_steal_o |=> !core_steal_o)
		else $error("more than one stolen cycle per word");
	count_dec_a: assert property (word_done_s |=> count_r == $past(count_r) - 14'h0001)
		else $error("word count did not decrement");
	page_carry_a: assert property (page_wrap_s |=> eaddr_r == 14'h0000
		&& page_r == $past(page_r) + 8'h01)
		else $error("page did not advance on address wrap");
	core_first_a: assert property (can_start && core_ext_req_i && busy_w
		|=> state_r == bmd_pkg::ST_EXT && acc_core_r)
		else $error("byte access taken ahead of core request");
	done_zero_a: assert property (done_pulse_r |-> count_r == 14'h0000 && !core_hold_o)
		else $error("completion raised with count nonzero");
	hold_restart_a: assert property ($fell(core_hold_o) |-> core_restart_o || !ctx_r
		|| $past(sw_count))
		else $error("core released without restart");
	unused_zero_a: assert property (state_r == bmd_pkg::ST_WORD && type_r[1]
		|-> imem_wdata_o[23:16] == 8'h00)
		else $error("unused bits not zero in byte format");
endmodule
`default_nettype wire

// ===== tb/bmd_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module bmd_mem_model (
	input  wire logic        clk_i,
	input  wire logic        rd_n_i,
	input  wire logic        wr_n_i,
	input  wire logic        sel_n_i,
	input  wire logic [13:0] addr_i,
	input  wire logic [23:0] data_i,
	output logic [23:0]      data_o
);
	logic [7:0] m [logic [21:0]];
	wire logic [21:0] k = {data_i[23:16], addr_i}; // page above in-page address
	wire logic [7:0]  b = m.exists(k) ? m[k] : k[7:0] ^ k[21:14];
	initial data_o = 24'h000000;
	// unselected bus flips every cycle so a stale byte never reads as good
	always @(posedge clk_i) begin
		if (!sel_n_i && !wr_n_i)
			m[k] = data_i[15:8];
		data_o <= (!sel_n_i && !rd_n_i) ? {8'h00, b, 8'h00} : ~data_o;
	end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic sys_clk_i = 0, reset_n_i = 0, ce_i = 1, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0;
	logic s_axi_bready_i = 0, s_axi_arvalid_i = 0, s_axi_rready_i = 0, boot_dma_i = 0;
	logic bus_request_n_i = 1, core_ext_req_i = 0, core_ext_write_i = 0, lp, cb = 0;
	logic [1:0] core_ext_space_i = '0, s_axi_bresp_o, s_axi_rresp_o, ext_data_oe_o, rr;
	logic [5:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
	logic [31:0] s_axi_wdata_i = '0, s_axi_rdata_o, rv;
	logic [3:0] s_axi_wstrb_i = 4'hf;
	logic [13:0] core_ext_addr_i = '0, imem_addr_o, ext_addr_o;
	logic [23:0] core_ext_wdata_i = '0, imem_rdata_i = '0, ext_data_i, lw;
	logic [23:0] core_ext_rdata_o, imem_wdata_o, ext_data_o;
	logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	logic bus_grant_n_o, core_ext_ack_o, imem_req_o, imem_write_o, imem_prog_o, core_steal_o;
	logic core_hold_o, core_restart_o, dma_done_o, ext_rd_n_o, ext_wr_n_o, ext_bus_oe_o;
	logic program_space_select_n_o, data_space_select_n_o, byte_space_select_n_o;
	logic io_space_select_n_o, composite_select_n_o;
	int bad_count = 0, tests_run = 0, nw = 0, nr = 0, mix = 0, nd = 0, bl = 0, cyc = 0;
	logic [23:0] ew [4] = '{24'hfa0607, 24'h00fa06, 24'h00fa00, 24'h0000fa};
	bmd_top DUT (.*);
	bmd_mem_model mem (.clk_i(sys_clk_i), .rd_n_i(ext_rd_n_o), .wr_n_i(ext_wr_n_o),
		// a prom on the byte select and a ram on the composite select share contents
		.sel_n_i(byte_space_select_n_o & composite_select_n_o), .addr_i(ext_addr_o),
		.data_i(ext_data_o),
		.data_o(ext_data_i));
	always #20 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) begin
		if (imem_req_o && imem_write_o) begin
			lw = imem_wdata_o;
			lp = imem_prog_o;
			nw++;
		end
		nr += core_restart_o;
		nd += dma_done_o;
		bl += !byte_space_select_n_o;
		// outputs are unknown before the first reset edge
		mix += reset_n_i && (composite_select_n_o !== (byte_space_select_n_o | !cb));
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1;
		s_axi_wvalid_i <= 1;
		fork
			begin do @(posedge sys_clk_i); while (!s_axi_awready_o); s_axi_awvalid_i <= 0; end
			begin do @(posedge sys_clk_i); while (!s_axi_wready_o); s_axi_wvalid_i <= 0; end
		join
		s_axi_bready_i <= 1;
		do @(posedge sys_clk_i); while (!s_axi_bvalid_o);
		s_axi_bready_i <= 0;
		rr = s_axi_bresp_o;
	endtask
	task automatic rd(input logic [5:0] a);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1;
		do @(posedge sys_clk_i); while (!s_axi_arready_o);
		s_axi_arvalid_i <= 0;
		s_axi_rready_i <= 1;
		do @(posedge sys_clk_i); while (!s_axi_rvalid_o);
		s_axi_rready_i <= 0;
		rv = s_axi_rdata_o;
		rr = s_axi_rresp_o;
	endtask
	// poll busy over the bus; the watchdog bounds a stuck engine
	task automatic run(input logic [31:0] n);
		wr(6'h10, n);
		do rd(6'h20); while (rv[0]);
		// done lands a cycle after busy drops, so look once more
		rd(6'h20);
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		#3000000;
		bad_count++;
		end_of_test;
	end
	initial begin
		repeat (3) @(posedge sys_clk_i);
		reset_n_i <= 1;
		rd(6'h18); chk(rv, 32'hb);
		rd(6'h1c); chk(rv[4:0], 5'h0f);
		rd(6'h24); chk(rr, 2'h2); chk(rv, 32'h0);
		bus_request_n_i <= 0;
		repeat (4) @(posedge sys_clk_i);
		chk(bus_grant_n_o, 0);
		chk(ext_bus_oe_o, 0);
		bus_request_n_i <= 1;
		repeat (4) @(posedge sys_clk_i);
		chk(bus_grant_n_o, 1);
		$display("test regs done");
		for (int t = 0; t < 4; t++) begin
			if (t == 3) begin
				wr(6'h18, 32'hf);
				cb = 1;
			end
			wr(6'h00, t);
			wr(6'h08, 32'h3fff);
			wr(6'h0c, 32'h5);
			nw = 0;
			nd = 0;
			run(32'h1);
			chk(rv[1], 1);
			chk(nd, 1);
			chk(nw, 1);
			chk(lw, ew[t]);
			chk(lp, t == 0);
			rd(6'h10); chk(rv, 0);
			rd(6'h0c); chk(rv, 32'h6);
			rd(6'h08); chk(rv, t == 0 ? 2 : t == 1);
			wr(6'h20, 32'h2);
		end
		chk(mix, 0);
		$display("test load done");
		imem_rdata_i <= 24'h00abcd;
		wr(6'h1c, 32'h1f);
		wr(6'h14, 32'hc0);
		wr(6'h00, 32'h5);
		wr(6'h04, 32'h0);
		wr(6'h08, 32'h10);
		wr(6'h0c, 32'h0);
		bl = 0;
		cyc = 0;
		wr(6'h10, 32'h1);
		// a core i/o read in region 2 lands while the store is pending
		core_ext_space_i <= 2'h2;
		core_ext_addr_i <= 14'h3c05;
		core_ext_req_i <= 1;
		do begin
			@(posedge sys_clk_i);
			cyc += !io_space_select_n_o;
		end while (!core_ext_ack_o);
		core_ext_req_i <= 0;
		chk(cyc, 4);
		chk(ext_addr_o, 14'h405);
		chk(composite_select_n_o, 0);
		do rd(6'h20); while (rv[0]);
		chk(mem.m[22'h10], 8'hab);
		chk(mem.m[22'h11], 8'hcd);
		chk(bl, 0);
		$display("test store done");
		boot_dma_i <= 1;
		reset_n_i <= 0;
		repeat (3) @(posedge sys_clk_i);
		reset_n_i <= 1;
		nw = 0;
		nr = 0;
		repeat (6) @(posedge sys_clk_i);
		chk(core_hold_o, 1);
		do rd(6'h20); while (rv[0]);
		repeat (2) @(posedge sys_clk_i);
		chk(nw, 32);
		chk(nr, 1);
		chk(core_hold_o, 0);
		$display("test boot done");
		end_of_test;
	end
endmodule
`default_nettype wire
